// [src/awd_dispatcher.sv]
/*
  actuator write dispatcher: takes cpu commands, filters and sends them
  one at a time on the ring with retries, raises alarms, runs shutdown.
  assumes lookup inputs are valid one cycle after cfg_addr changes.
*/
module awd_dispatcher #(
  parameter int unsigned RX_TIMEOUT_CYCLES = awd_pkg::RX_TIMEOUT_CYC,
  parameter int unsigned WR_ALARM_CYCLES   = awd_pkg::WR_ALARM_CYC
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  // cpu command writes
  input  wire logic               cmd_valid,
  input  wire awd_pkg::awd_cmd_t  cmd,
  output logic                    cmd_taken,
  output logic                    write_cmd_alarm,
  // register port
  input  wire logic               reg_wr,
  input  wire logic [15:0]        reg_addr,
  input  wire logic [15:0]        reg_wdata,
  output logic      [15:0]        reg_rdata,
  // actuator database lookup
  output logic      [7:0]         cfg_addr,
  input  wire logic               cfg_in_scan,
  input  wire logic [2:0]         cfg_dev_type,
  input  wire logic [15:0]        fb_setpoint,
  input  wire logic [15:0]        fb_aout,
  input  wire logic [1:0]         fb_relay,
  // host readback
  input  wire logic [7:0]         rb_addr,
  input  wire awd_pkg::awd_kind_t rb_kind,
  output logic      [15:0]        rb_value,
  output logic      [15:0]        rb_status,
  // ring transmit and acknowledge
  output logic                    tx_valid,
  output awd_pkg::awd_tx_t        tx,
  input  wire logic               tx_ready,
  input  wire logic               rx_ack,
  input  wire logic [7:0]         rx_addr,
  // priority scan and alarms
  output logic                    pri_valid,
  output logic      [7:0]         pri_addr,
  output logic      [255:0]       link_loss,
  output logic      [255:0]       esd_alarm,
  output logic                    esd_active
);
  import awd_pkg::*;

  localparam logic [31:0] TO_LAST = 32'(RX_TIMEOUT_CYCLES - 1);
  localparam logic [31:0] WR_LAST = 32'(WR_ALARM_CYCLES - 1);

  awd_state_t        state, next_state;
  awd_kind_t         kind, next_kind;
  awd_tx_t           next_tx;
  logic [7:0]        cur_addr, next_addr;
  logic              esd_mode, next_mode, rest, next_rest, sent, next_sent;
  logic              port_b, next_port, next_tx_valid, next_pri_valid;
  logic [1:0]        tries, next_tries;
  logic [3:0]        clr, next_clr, pend_here, want, pick_oh;
  logic [1:0]        pick_idx, cmd_k, rb_k;
  logic [31:0]       timer, next_timer, wait_cnt, next_wait;
  logic [7:0]        next_pri_addr;
  logic [255:0]      next_link, next_esd_alarm;
  logic [3:0][255:0] pend, next_pend;
  logic              esd_req, next_esd_req, next_esd_active, next_wca, take, timeout, ack_here;
  logic [15:0]       esd_reg, next_esd_reg, next_reg_rdata, next_rb_value, next_rb_status;
  logic [3:0][15:0]  rd_val, rb_val;
  logic [3:0]        mem_we;
  logic [7:0]        mem_waddr;
  logic [15:0]       mem_wdata;

  assign cfg_addr = cur_addr;
  assign cmd_k    = 2'(cmd.kind);
  assign rb_k     = 2'(rb_kind);
  assign timeout  = (timer == TO_LAST);
  assign ack_here = rx_ack && (rx_addr == cur_addr);
  // the record under work is not touched by new commands
  assign take = cmd_valid && !cmd_taken && (state != S_DONE) && ((state == S_IDLE) || (cmd.addr != cur_addr));

  // per-kind value stores
  for (genvar k = 0; k < 4; k++) begin : g_mem
    awd_mem #(.W(16), .AW(8)) u_mem (
      .clk_sys (clk_sys),
      .we      (mem_we[k]),
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .ra_addr (cur_addr),
      .ra_data (rd_val[k]),
      .rb_addr (rb_addr),
      .rb_data (rb_val[k])
    );
    assign pend_here[k] = pend[k][cur_addr];
  end

  // memory write select
  always_comb begin
    mem_we    = 4'h0;
    mem_waddr = cmd.addr;
    mem_wdata = cmd.value;
    if (state == S_DONE && !esd_mode) begin
      mem_we[0] = clr[0];
      mem_waddr = cur_addr;
      mem_wdata = 16'h0000;
    end else if (take && cmd.kind != K_ESD) begin
      mem_we[cmd_k] = 1'b1;
    end
  end

  // filter and pick the next kind for this address
  always_comb begin
    want[0] = pend_here[0];
    want[1] = pend_here[1] && cfg_dev_type > DT_NO_ANALOG_MAX && rd_val[1] != fb_setpoint;
    want[2] = pend_here[2] && cfg_dev_type > DT_NO_ANALOG_MAX && rd_val[2] != fb_aout;
    want[3] = pend_here[3] && (cfg_dev_type inside {DT_RELAY_A, DT_RELAY_B, DT_RELAY_C})
              && rd_val[3][1:0] != fb_relay;
    if (!cfg_in_scan) begin
      want = 4'h0;
    end
    pick_oh  = want & 4'(~want + 4'h1);
    pick_idx = pick_oh[0] ? 2'h0 : pick_oh[1] ? 2'h1 : pick_oh[2] ? 2'h2 : 2'h3;
  end

  // dispatcher state machine
  always_comb begin
    next_state     = state;
    next_addr      = cur_addr;
    next_mode      = esd_mode;
    next_kind      = kind;
    next_clr       = clr;
    next_rest      = rest;
    next_tries     = tries;
    next_port      = port_b;
    next_timer     = timer;
    next_tx        = tx;
    next_sent      = sent;
    next_pend      = pend;
    next_link      = link_loss;
    next_esd_alarm = esd_alarm;
    next_esd_req   = esd_req;
    next_pri_valid = 1'b0;
    next_pri_addr  = pri_addr;
    if (rx_ack) begin
      next_link[rx_addr] = 1'b0;
    end
    unique case (state)
      S_IDLE: begin
        if (esd_req) begin
          next_mode    = 1'b1;
          next_esd_req = 1'b0;
          next_addr    = ADDR_FIRST;
          next_state   = S_SCAN;
        end else if (|pend || take) begin
          next_mode  = 1'b0;
          next_addr  = 8'h00;
          next_state = S_SCAN;
        end
      end
      S_SCAN: begin
        if (esd_mode) begin
          next_state = esd_active ? S_PICK : S_IDLE;
        end else if (esd_req) begin
          next_state = S_IDLE;
        end else if (|pend_here) begin
          next_state = S_PICK;
        end else if (cur_addr == ADDR_LAST) begin
          next_state = S_IDLE;
        end else begin
          next_addr = cur_addr + 8'h01;
        end
      end
      S_PICK: begin
        next_tries = 2'h0;
        next_port  = 1'b0;
        next_sent  = 1'b0;
        next_rest  = 1'b0;
        if (esd_mode) begin
          if (cfg_in_scan && !link_loss[cur_addr]) begin
            next_kind  = K_ESD;
            next_tx    = '{kind: K_ESD, addr: cur_addr, port_b: 1'b0, data: ESD_TRIGGER};
            next_state = S_SEND;
          end else begin
            next_state = S_DONE;
          end
        end else begin
          // filtered kinds are dropped, wanted but unpicked stay pending
          next_clr  = pend_here & ~(want & ~pick_oh);
          next_rest = |(want & ~pick_oh);
          next_kind = awd_kind_t'({1'b0, pick_idx});
          next_tx   = '{kind: awd_kind_t'({1'b0, pick_idx}), addr: cur_addr, port_b: 1'b0, data: rd_val[pick_idx]};
          next_state = (|want) ? S_SEND : S_DONE;
        end
      end
      S_SEND: begin
        if (tx_ready) begin
          next_timer = 32'h0;
          next_sent  = 1'b1;
          next_state = S_ACK;
        end
      end
      S_ACK: begin
        next_timer = timer + 32'h1;
        if (ack_here) begin
          if (esd_mode) begin
            next_esd_alarm[cur_addr] = 1'b0;
          end
          next_state = S_DONE;
        end else if (timeout) begin
          if (tries != LAST_TRY) begin
            next_tries = tries + 2'h1;
            next_state = S_SEND;
          end else if (!port_b && !esd_mode) begin
            next_port      = 1'b1;
            next_tries     = 2'h0;
            next_tx.port_b = 1'b1;
            next_state     = S_SEND;
          end else begin
            if (esd_mode) begin
              next_esd_alarm[cur_addr] = 1'b1;
            end else begin
              next_link[cur_addr] = 1'b1;
            end
            next_state = S_DONE;
          end
        end
      end
      S_DONE: begin
        if (!esd_mode) begin
          for (int k = 0; k < 4; k++) begin
            if (clr[k]) begin
              next_pend[k][cur_addr] = 1'b0;
            end
          end
          if (kind == K_SP && sent) begin
            next_pri_valid = 1'b1;
            next_pri_addr  = cur_addr;
          end
        end
        if (rest) begin
          next_state = S_SCAN;
        end else if (cur_addr == ADDR_LAST) begin
          next_mode  = 1'b0;
          next_state = S_IDLE;
        end else begin
          next_addr  = cur_addr + 8'h01;
          next_state = S_SCAN;
        end
      end
      default: next_state = S_IDLE;
    endcase
    // new commands win over the clear
    if (take && cmd.kind != K_ESD) begin
      next_pend[cmd_k][cmd.addr] = 1'b1;
      if (cmd.kind == K_DISC) begin
        next_pri_valid = 1'b1;
        next_pri_addr  = cmd.addr;
      end
    end
    if (reg_wr && reg_addr == ESD_REG_ADDR && reg_wdata == ESD_TRIGGER) begin
      next_esd_req = 1'b1;
    end
    next_tx_valid = (next_state == S_SEND);
  end

  // command acceptance, write alarm, registers and readback
  always_comb begin
    next_wait = (cmd_valid && !cmd_taken && !take) ? ((wait_cnt == WR_LAST) ? wait_cnt : wait_cnt + 32'h1) : 32'h0;
    next_wca = take ? 1'b0 : ((wait_cnt == WR_LAST) ? 1'b1 : write_cmd_alarm);
    next_esd_reg    = (reg_wr && reg_addr == ESD_REG_ADDR) ? reg_wdata : esd_reg;
    next_esd_active = esd_active;
    if (reg_wr && reg_addr == ESD_REG_ADDR && reg_wdata == ESD_TRIGGER) begin
      next_esd_active = 1'b1;
    end else if (reg_wr && reg_addr == ESD_REG_ADDR && reg_wdata == ESD_CLEAR) begin
      next_esd_active = 1'b0;
    end
    next_reg_rdata = (reg_addr == ESD_REG_ADDR) ? esd_reg : 16'h0000;
    next_rb_value  = (rb_kind == K_ESD) ? esd_reg : rb_val[rb_k];
    next_rb_status = 16'h0000;
    next_rb_status[LINK_LOSS_BIT] = link_loss[rb_addr];
  end

  // registers; the pending flags are cleared by reset, the value stores are not
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= S_IDLE;
      cur_addr <= 8'h00;
      esd_mode <= 1'b0;
      kind <= K_DISC;
      clr <= 4'h0;
      rest <= 1'b0;
      tries <= 2'h0;
      port_b <= 1'b0;
      timer <= 32'h0;
      tx <= '0;
      tx_valid <= 1'b0;
      sent <= 1'b0;
      pend <= '0;
      link_loss <= '0;
      esd_alarm <= '0;
      esd_req <= 1'b0;
      pri_valid <= 1'b0;
      pri_addr <= 8'h00;
      cmd_taken <= 1'b0;
      wait_cnt <= 32'h0;
      write_cmd_alarm <= 1'b0;
      esd_reg <= ESD_RESET_VAL;
      esd_active <= 1'b0;
      reg_rdata <= 16'h0000;
      rb_value <= 16'h0000;
      rb_status <= 16'h0000;
    end else begin
      state <= next_state;
      cur_addr <= next_addr;
      esd_mode <= next_mode;
      kind <= next_kind;
      clr <= next_clr;
      rest <= next_rest;
      tries <= next_tries;
      port_b <= next_port;
      timer <= next_timer;
      tx <= next_tx;
      tx_valid <= next_tx_valid;
      sent <= next_sent;
      pend <= next_pend;
      link_loss <= next_link;
      esd_alarm <= next_esd_alarm;
      esd_req <= next_esd_req;
      pri_valid <= next_pri_valid;
      pri_addr <= next_pri_addr;
      cmd_taken <= take;
      wait_cnt <= next_wait;
      write_cmd_alarm <= next_wca;
      esd_reg <= next_esd_reg;
      esd_active <= next_esd_active;
      reg_rdata <= next_reg_rdata;
      rb_value <= next_rb_value;
      rb_status <= next_rb_status;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_last_try_b;
    state == S_ACK && timeout && !ack_here && tries == LAST_TRY && port_b;
  endsequence
  sequence s_esd_write(logic [15:0] v);
    reg_wr && reg_addr == ESD_REG_ADDR && reg_wdata == v;
  endsequence

  AST_IMMEDIATE: assert property (state == S_IDLE && take && !esd_req |=> state == S_SCAN)
    else $error("command did not start processing");
  AST_WR_ALARM: assert property (cmd_valid && !take && !cmd_taken && wait_cnt == WR_LAST |=> write_cmd_alarm)
    else $error("write alarm missing after limit");
  AST_OFF_SCAN: assert property (state == S_PICK && !esd_mode && !cfg_in_scan |=> state == S_DONE ##1 !tx_valid)
    else $error("off-scan command was sent");
  AST_PORT_SWITCH: assert property (state == S_ACK && timeout && !ack_here && tries == LAST_TRY && !port_b && !esd_mode
    |=> state == S_SEND && tx_valid && tx.port_b && tries == 2'h0)
    else $error("no switch to port b after three tries");
  AST_LINK_LOSS: assert property (s_last_try_b ##0 !esd_mode |=> link_loss[$past(cur_addr)] && state == S_DONE)
    else $error("link loss not set after both ports failed");
  AST_ASCEND: assert property (state == S_DONE && !rest && cur_addr != ADDR_LAST |=> cur_addr == $past(cur_addr) + 8'h01)
    else $error("addresses not visited in ascending order");
  AST_DISC_ZERO: assert property (state == S_DONE && !esd_mode && clr[0] |-> mem_we[0] && mem_wdata == 16'h0000)
    else $error("sent discrete command not zeroed");
  AST_PRI_DISC: assert property (take && cmd.kind == K_DISC |=> pri_valid && pri_addr == $past(cmd.addr))
    else $error("discrete command not put in priority scan");
  AST_NO_ANALOG: assert property (state == S_PICK && !esd_mode && cfg_dev_type <= DT_NO_ANALOG_MAX
    |=> !(tx_valid && tx.kind inside {K_SP, K_AO}))
    else $error("analog write to device type 0 or 1");
  AST_ESD_START: assert property (s_esd_write(ESD_TRIGGER) |=> esd_active && esd_req)
    else $error("shutdown not started by write of 7");
  AST_ESD_ALARM: assert property (state == S_ACK && esd_mode && timeout && !ack_here && tries == LAST_TRY
    |=> esd_alarm[$past(cur_addr)] && !tx_valid)
    else $error("shutdown alarm missing after three tries");
  AST_ESD_END: assert property (s_esd_write(ESD_CLEAR) |=> !esd_active)
    else $error("shutdown not ended by write of 0");
endmodule // awd_dispatcher

// [src/awd_pkg.sv]
/*
  constants, types and command codes of the actuator write dispatcher.
  assumes one 200 MHz clock and 8-bit slave addresses.
*/
package awd_pkg;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned RX_TIMEOUT_MS = 50;
  localparam int unsigned RX_TIMEOUT_CYC = RX_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned WR_ALARM_S    = 2;
  localparam int unsigned WR_ALARM_CYC  = WR_ALARM_S * CLK_HZ;

  // shutdown register
  localparam logic [15:0] ESD_REG_ADDR  = 16'h9e7f;
  localparam logic [15:0] ESD_TRIGGER   = 16'h0007;
  localparam logic [15:0] ESD_CLEAR     = 16'h0000;
  localparam logic [15:0] ESD_RESET_VAL = 16'h0000;

  // retry counts, stored as last try index
  localparam logic [1:0]  LAST_TRY      = 2'h2;
  localparam int          LINK_LOSS_BIT = 13;

  // device types
  localparam logic [2:0]  DT_NO_ANALOG_MAX = 3'h1;
  localparam logic [2:0]  DT_RELAY_A    = 3'h1;
  localparam logic [2:0]  DT_RELAY_B    = 3'h3;
  localparam logic [2:0]  DT_RELAY_C    = 3'h5;

  localparam logic [7:0]  ADDR_FIRST    = 8'h01;
  localparam logic [7:0]  ADDR_LAST     = 8'hff;

  typedef enum logic [2:0] {
    K_DISC = 3'h0,
    K_SP   = 3'h1,
    K_AO   = 3'h2,
    K_RLY  = 3'h3,
    K_ESD  = 3'h4
  } awd_kind_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SCAN = 3'h1,
    S_PICK = 3'h2,
    S_SEND = 3'h3,
    S_ACK  = 3'h4,
    S_DONE = 3'h5
  } awd_state_t;

  typedef struct packed {
    awd_kind_t   kind;
    logic [7:0]  addr;
    logic [15:0] value;
  } awd_cmd_t;

  typedef struct packed {
    awd_kind_t   kind;
    logic [7:0]  addr;
    logic        port_b;
    logic [15:0] data;
  } awd_tx_t;
endpackage

// [src/awd_mem.sv]
/*
  per-address value store: one write port, two registered read ports.
  assumes contents are undefined until written.
*/
module awd_mem #(
  parameter int W  = 16,
  parameter int AW = 8
) (
  // clock
  input  wire logic          clk_sys,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read ports
  input  wire logic [AW-1:0] ra_addr,
  output logic      [W-1:0]  ra_data,
  input  wire logic [AW-1:0] rb_addr,
  output logic      [W-1:0]  rb_data
);
  logic [W-1:0] mem [2**AW];

  // write and registered reads
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    ra_data <= mem[ra_addr];
    rb_data <= mem[rb_addr];
  end
endmodule // awd_mem

// [verif/awd_ring_model.sv]
/*
  actuator-side model: database lookup tables and ring acknowledgments.
  assumes the bench presets the tables before reset is released.
*/
module awd_ring_model (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // database lookup
  input  wire logic [7:0]       cfg_addr,
  output logic                  cfg_in_scan,
  output logic      [2:0]       cfg_dev_type,
  output logic      [15:0]      fb_setpoint,
  output logic      [15:0]      fb_aout,
  output logic      [1:0]       fb_relay,
  // ring
  input  wire logic             tx_valid,
  input  wire awd_pkg::awd_tx_t tx,
  output logic                  tx_ready,
  output logic                  rx_ack,
  output logic      [7:0]       rx_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import awd_pkg::*;
  logic        scan   [256] = '{default: 1'b0};
  logic        silent [256] = '{default: 1'b0};
  logic [2:0]  dtype  [256] = '{default: 3'h2};
  logic [15:0] sp     [256] = '{default: 16'h0000};
  logic [15:0] ao     [256] = '{default: 16'h0000};
  logic [1:0]  rl     [256] = '{default: 2'h0};
  int          ack_dly      = 3;
  int          wait_n       = 0;
  logic [7:0]  last         = 8'h00;
  awd_tx_t     log_q [$];

  // lookup answers describe the address one cycle later
  always @(posedge clk_sys) begin
    cfg_in_scan  <= scan[cfg_addr];
    cfg_dev_type <= dtype[cfg_addr];
    fb_setpoint  <= sp[cfg_addr];
    fb_aout      <= ao[cfg_addr];
    fb_relay     <= rl[cfg_addr];
  end

  always @(posedge clk_sys) begin
    rx_ack   <= 1'b0;
    rx_addr  <= ~last;  // idle line must not keep the last address
    tx_ready <= tx_valid && !tx_ready && !sys_rst;
    if (tx_valid && tx_ready) begin
      log_q.push_back(tx);
      last   <= tx.addr;
      wait_n <= silent[tx.addr] ? 0 : ack_dly;  // silent nodes never answer
    end else if (wait_n == 1) begin
      rx_ack  <= 1'b1;
      rx_addr <= last;
      wait_n  <= 0;
    end else if (wait_n > 1) begin
      wait_n <= wait_n - 1;
    end
  end
endmodule // awd_ring_model

// [verif/awd_dispatcher_tb.sv]
/*
  self-checking bench of the write dispatcher with the actuator model.
  assumes short time-out (20) and alarm (50) counts.
*/
module awd_dispatcher_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import awd_pkg::*;
  logic clk_sys = 0, sys_rst = 1, cmd_valid = 0, reg_wr = 0;
  awd_cmd_t cmd = '0;
  logic [15:0] reg_addr = ESD_REG_ADDR, reg_wdata = 16'h0000;
  logic [7:0] rb_addr = 8'h00;
  awd_kind_t rb_kind = K_DISC;
  logic cmd_taken, write_cmd_alarm, cfg_in_scan, tx_valid, tx_ready, rx_ack, pri_valid, esd_active;
  logic [15:0] reg_rdata, rb_value, rb_status, fb_setpoint, fb_aout;
  logic [7:0] cfg_addr, rx_addr, pri_addr;
  logic [2:0] cfg_dev_type;
  logic [1:0] fb_relay;
  logic [255:0] link_loss, esd_alarm;
  awd_tx_t tx;
  logic [7:0] pri_q [$];
  logic [7:0] sd_addrs [6] = '{8'd10, 8'd20, 8'd30, 8'd40, 8'd41, 8'd42};
  int errors = 0, comparisons = 0, n;

  always #2.5 clk_sys = ~clk_sys;

  awd_dispatcher #(.RX_TIMEOUT_CYCLES(20), .WR_ALARM_CYCLES(50)) i_dut (.*);
  awd_ring_model i_ring (.*);

  always @(posedge clk_sys) if (pri_valid === 1'b1) pri_q.push_back(pri_addr);

  task automatic finish_test;
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input awd_kind_t k, input logic [7:0] a, input logic [15:0] v);
    cmd       <= '{kind: k, addr: a, value: v};
    cmd_valid <= 1'b1;
    do @(posedge clk_sys); while (cmd_taken !== 1'b1);
    cmd_valid <= 1'b0;
    @(posedge clk_sys);
  endtask

  // quiet once no ring write is offered for 300 cycles
  task automatic settle;
    for (int q = 0; q < 300; q = (tx_valid === 1'b1) ? 0 : q + 1) @(posedge clk_sys);
  endtask

  task automatic exp_tx(input awd_kind_t k, input logic [7:0] a, input logic pb, input logic [15:0] d);
    awd_tx_t t;
    t = '0;
    if (i_ring.log_q.size() > 0) t = i_ring.log_q.pop_front();
    chk(t, {k, a, pb, d});
  endtask

  task automatic exp_pri(input logic [7:0] a);
    logic [7:0] p;
    p = 8'h00;
    if (pri_q.size() > 0) p = pri_q.pop_front();
    chk(p, a);
  endtask

  task automatic wreg(input logic [15:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input awd_kind_t k, input logic [7:0] a);
    rb_kind <= k;
    rb_addr <= a;
    repeat (3) @(posedge clk_sys);
  endtask

  // hang guard, far beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk_sys);
    errors++;
    finish_test;
  end

  initial begin
    foreach (i_ring.scan[i]) i_ring.scan[i] = (i inside {10, 20, 30, 40, 41, 42, 43});
    i_ring.dtype[40] = 3'h1;
    i_ring.dtype[41] = 3'h0;
    i_ring.dtype[42] = 3'h3;
    i_ring.sp[20]    = 16'h0064;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk({esd_active, tx_valid, |link_loss, |esd_alarm, write_cmd_alarm}, 0);
    chk(reg_rdata, ESD_RESET_VAL);
    send(K_SP, 8'h09, 16'h0005);
    settle;
    send(K_DISC, 8'h14, 16'h0003);
    send(K_DISC, 8'h0a, 16'h0001);
    settle;
    exp_tx(K_DISC, 8'h0a, 1'b0, 16'h0001);
    exp_tx(K_DISC, 8'h14, 1'b0, 16'h0003);
    exp_pri(8'h14);
    exp_pri(8'h0a);
    rd(K_DISC, 8'h0a);
    chk(rb_value, 0);
    // equal or wrong-type values are filtered, others go out
    send(K_SP, 8'h14, 16'h0064);
    send(K_SP, 8'h14, 16'h00c8);
    send(K_SP, 8'h28, 16'h0005);
    send(K_AO, 8'h29, 16'h0005);
    send(K_AO, 8'h0a, 16'h0007);
    send(K_RLY, 8'h2a, 16'h0001);
    send(K_RLY, 8'h0a, 16'h0001);
    settle;
    send(K_RLY, 8'h2a, 16'h0000);
    send(K_AO, 8'h0a, 16'h0000);
    settle;
    exp_tx(K_SP, 8'h14, 1'b0, 16'h00c8);
    exp_pri(8'h14);
    // the analog write for 0x0a lands after the sweep passed it, so it goes out one sweep later
    exp_tx(K_RLY, 8'h2a, 1'b0, 16'h0001);
    exp_tx(K_AO, 8'h0a, 1'b0, 16'h0007);
    chk(i_ring.log_q.size(), 0);
    rd(K_SP, 8'h14);
    chk(rb_value, 16'h00c8);
    // silent node: retries, link loss, then a late waiting command
    i_ring.silent[30] = 1'b1;
    send(K_DISC, 8'h1e, 16'h0001);
    while (tx_valid !== 1'b1) @(posedge clk_sys);
    fork
      send(K_SP, 8'h1e, 16'h0009);
      begin
        for (n = 0; write_cmd_alarm !== 1'b1 && n < 200; n++) @(posedge clk_sys);
        chk(n >= 45 && n <= 60, 1);
      end
    join
    chk(write_cmd_alarm, 0);
    settle;
    for (int i = 0; i < 12; i++) exp_tx(i < 6 ? K_DISC : K_SP, 8'h1e, (i % 6) > 2, i < 6 ? 16'h1 : 16'h9);
    chk(link_loss[30], 1);
    rd(K_DISC, 8'h1e);
    chk(rb_status, 16'h2000);
    exp_pri(8'h1e);
    exp_pri(8'h1e);
    i_ring.silent[30] = 1'b0;
    send(K_SP, 8'h1e, 16'h000a);
    settle;
    exp_tx(K_SP, 8'h1e, 1'b0, 16'h000a);
    exp_pri(8'h1e);
    chk(link_loss[30], 0);
    // shutdown sweep with slow answers and one silent node
    i_ring.silent[43] = 1'b1;
    i_ring.ack_dly    = 15;
    wreg(ESD_REG_ADDR, ESD_TRIGGER);
    chk(esd_active, 1);
    settle;
    foreach (sd_addrs[i]) exp_tx(K_ESD, sd_addrs[i], 1'b0, ESD_TRIGGER);
    for (int i = 0; i < 3; i++) exp_tx(K_ESD, 8'h2b, 1'b0, 16'h0007);
    chk({esd_alarm[43], esd_alarm[10]}, 2'b10);
    chk(reg_rdata, ESD_TRIGGER);
    wreg(ESD_REG_ADDR, ESD_CLEAR);
    chk(esd_active, 0);
    wreg(16'h9e7e, ESD_TRIGGER);
    chk({esd_active, reg_rdata}, 0);
    settle;
    chk(i_ring.log_q.size() + pri_q.size(), 0);
    finish_test;
  end
endmodule // awd_dispatcher_tb
